// >>> core/edtc_pkg.sv
// Purpose: shared constants and types for the dram timing control block
// Assumes: one 200 MHz clock, classic wishbone register access
// Notes:   tap index n-1 holds delay tap Tn
package edtc_pkg;

	// cycle mode select encodings sent to the dram controller
	typedef enum logic [1:0] {
		EDTC_MODE_REFRESH  = 2'b00,
		EDTC_MODE_SCRUB    = 2'b01,
		EDTC_MODE_RDWR     = 2'b10,
		EDTC_MODE_RESET    = 2'b11
	} edtc_mode_t;

	typedef enum logic [1:0] {
		EDTC_ST_IDLE = 2'b00,
		EDTC_ST_RUN  = 2'b01,
		EDTC_ST_END  = 2'b10
	} edtc_state_t;

	localparam int unsigned EDTC_NTAPS     = 10;
	localparam int unsigned EDTC_TAP_T2    = 1;
	localparam int unsigned EDTC_TAP_T3    = 2;
	localparam int unsigned EDTC_TAP_T4    = 3;
	localparam int unsigned EDTC_TAP_T5    = 4;
	localparam int unsigned EDTC_TAP_T6    = 5;
	localparam int unsigned EDTC_TAP_T7    = 6;
	localparam int unsigned EDTC_TAP_T8    = 7;
	localparam logic [3:0]  EDTC_WAKE_LAST = 4'h7;
	localparam logic [3:0]  EDTC_WAKE_RST  = 4'h0;

	// register map, byte addresses
	localparam logic [7:0]  EDTC_ADR_CTRL   = 8'h00;
	localparam logic [7:0]  EDTC_ADR_STATUS = 8'h04;
	localparam logic [7:0]  EDTC_ADR_SYND   = 8'h08;
	localparam int unsigned EDTC_CTRL_SCRUB = 0;
	localparam int unsigned EDTC_CTRL_IRQEN = 1;
	localparam logic [1:0]  EDTC_CTRL_RST   = 2'h3;
	localparam logic [8:0]  EDTC_SYND_RST   = 9'h000;

endpackage // edtc_pkg

// >>> core/edtc_tap_reg.sv
// Purpose: one register per delay tap, set by that tap's rising edge
// Assumes: taps are synchronous to i_mclk
// Notes:   clear wins over set so a new cycle starts from a clean tap state
`timescale 1ns/1ps
module edtc_tap_reg
	import edtc_pkg::*;
(
	input  wire logic                  i_mclk,
	input  wire logic                  i_sys_rst,
	input  wire logic [EDTC_NTAPS-1:0] i_tap,
	input  wire logic                  i_clear,
	output logic      [EDTC_NTAPS-1:0] o_tap_q,
	output logic      [EDTC_NTAPS-1:0] o_tap_rise
);
	import edtc_pkg::*;

	logic [EDTC_NTAPS-1:0] tap_prev_q;

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tap_prev_q <= '0;
		end else begin
			tap_prev_q <= i_tap;
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_tap_q <= '0;
		end else if (i_clear) begin
			o_tap_q <= '0;
		end else begin
			o_tap_q <= o_tap_q | (i_tap & ~tap_prev_q);
		end
	end

	// one-cycle pulse when a registered tap first becomes set
	assign o_tap_rise = (i_tap & ~tap_prev_q & ~o_tap_q) & {EDTC_NTAPS{~i_clear}};

	tap_clear_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		i_clear |=> (o_tap_q == '0)) else $error("tap registers not cleared by cycle end");

endmodule // edtc_tap_reg

// >>> core/edtc_wb_regs.sv
// Purpose: classic wishbone slave holding control, status and syndrome
// Assumes: 32-bit data, word-aligned byte addresses
// Notes:   ack follows one cycle after the request; unmapped reads give zero
`timescale 1ns/1ps
module edtc_wb_regs
	import edtc_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [31:0] i_wb_dat,
	input  wire logic [3:0]  i_wb_sel,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	input  wire logic [31:0] i_status,
	input  wire logic [8:0]  i_syndrome,
	output logic      [1:0]  o_ctrl,
	output logic             o_syndrome_read_strobe
);
	import edtc_pkg::*;

	logic req;
	assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= req;
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_ctrl <= EDTC_CTRL_RST;
		// the write lands on the edge where the master sees ack
		end else if (i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr == EDTC_ADR_CTRL) begin
			o_ctrl <= i_wb_dat[1:0];
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_wb_dat <= '0;
		end else if (req && !i_wb_we) begin
			case (i_wb_adr)
				EDTC_ADR_CTRL:   o_wb_dat <= {30'h0, o_ctrl};
				EDTC_ADR_STATUS: o_wb_dat <= i_status;
				EDTC_ADR_SYND:   o_wb_dat <= {23'h0, i_syndrome};
				default:         o_wb_dat <= '0;
			endcase
		end
	end

	// a read of the syndrome word is the software access that clears the irq
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_syndrome_read_strobe <= 1'b0;
		end else begin
			o_syndrome_read_strobe <= req && !i_wb_we && i_wb_adr == EDTC_ADR_SYND;
		end
	end

	ack_one_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_wb_ack |=> !o_wb_ack) else $error("ack held longer than one cycle");

endmodule // edtc_wb_regs

// >>> core/edtc_core.sv
// Purpose: dram timing control: cycle sequencing, modes, wake-up, fill, edc strobes
// Assumes: delay line taps and host bus pins are synchronous to i_mclk
// Notes:   tap index n-1 is tap Tn; strobes are active high unless named _n
// Summary of operation
// - mode 00 refresh, 01 scrub/init, 10 rdwr, 11 reset
// - row strobe request starts taps and bank strobe
// - cycle end returns control to idle
// - taps registered individually, cleared at cycle end
// - wake counter counts tap-eight events up to seven
// - wake-up complete holds until fill inactive
// - reset rising edge sets fill until fill complete
// - held error set at end, sampled at tap two
// - multibit irq at tap four, cleared by syndrome read
// - pulsed column strobe only in rmw and scrub
// - separate write strobe per bank
// - edc control high outputs, low generates check bits
// - edc input latch transparent high, captures low
// - host latch transparent while high
// - word select picks low or high half
// - low address and high-byte enable give byte selects
// - syndrome latch qualified by mode, row request, tap three
// - lane gates qualified by lane gate qualifier
// - internal bus enables include host write term
// - fill writes input latch word with check bits
// - refresh without scrubbing is row-strobe only
// - host refresh line raises refresh request
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module edtc_core
	import edtc_pkg::*;
(
	input  wire logic                  i_mclk,
	input  wire logic                  i_sys_rst,
	input  wire logic                  i_wb_cyc,
	input  wire logic                  i_wb_stb,
	input  wire logic                  i_wb_we,
	input  wire logic [7:0]            i_wb_adr,
	input  wire logic [31:0]           i_wb_dat,
	input  wire logic [3:0]            i_wb_sel,
	output logic      [31:0]           o_wb_dat,
	output logic                       o_wb_ack,
	input  wire logic                  i_host_reset,
	input  wire logic                  i_host_refresh,
	input  wire logic                  i_mem_access,
	input  wire logic                  i_host_write,
	input  wire logic [1:0]            i_addr_lo,
	input  wire logic                  i_high_byte_en_n,
	input  wire logic [1:0]            i_bank_sel,
	input  wire logic [EDTC_NTAPS-1:0] i_delay_tap,
	input  wire logic                  i_fill_complete,
	input  wire logic                  i_edc_err,
	input  wire logic                  i_edc_merr,
	input  wire logic [8:0]            i_check_bits,
	output logic                       o_row_strobe_request,
	output edtc_mode_t                 o_cycle_mode_select,
	output logic                       o_cycle_end,
	output logic                       o_refresh_request,
	output logic                       o_multibit_irq,
	output logic                       o_pulsed_column_strobe,
	output logic      [2:0]            o_bank_write,
	output logic                       o_edc_out_latch_or_generate,
	output logic                       o_edc_input_capture,
	output logic                       o_system_latch_open,
	output logic                       o_low_half_drive_n,
	output logic                       o_high_half_drive_n,
	output logic      [3:0]            o_byte_write_sel,
	output logic      [3:0]            o_lane_gate,
	output logic                       o_syndrome_capture_n,
	output logic                       o_wakeup_done,
	output logic                       o_fill_active
);
	import edtc_pkg::*;

	edtc_state_t           state_q;
	edtc_state_t           state_d;
	edtc_mode_t            mode_d;
	logic [EDTC_NTAPS-1:0] tap_q;
	logic [EDTC_NTAPS-1:0] tap_rise;
	logic [1:0]            ctrl;
	logic                  syn_rd;
	logic [3:0]            wake_cnt_q;
	logic                  held_err_q;
	logic                  irq_q;
	logic                  rst_prev_q;
	logic                  rfr_prev_q;
	logic                  refresh_pend_q;
	logic                  fill_prev_q;
	logic [8:0]            syndrome_q;
	logic                  write_q;
	logic                  start;
	logic                  end_hit;
	logic                  is_rdwr;
	logic                  rmw_or_scrub;
	logic                  host_rd;
	logic                  syn_hit;
	logic [3:0]            byte_sel;

	// byte write selects from the two low address bits and high-byte enable
	function automatic logic [3:0] byte_decode(input logic [1:0] a, input logic sbhe_n);
		logic [3:0] s;
		s = 4'h0;
		s[{a[1], 1'b0}] = ~a[0];
		s[{a[1], 1'b1}] = ~sbhe_n;
		return s;
	endfunction

	function automatic logic [2:0] bank_decode(input logic [1:0] b);
		logic [2:0] s;
		s = 3'h0;
		if (b < 2'd3) begin
			s[b] = 1'b1;
		end
		return s;
	endfunction

	edtc_tap_reg u_taps (
		.i_mclk     (i_mclk),
		.i_sys_rst  (i_sys_rst),
		.i_tap      (i_delay_tap),
		.i_clear    (o_cycle_end),
		.o_tap_q    (tap_q),
		.o_tap_rise (tap_rise)
	);

	edtc_wb_regs u_regs (
		.i_mclk                 (i_mclk),
		.i_sys_rst              (i_sys_rst),
		.i_wb_cyc               (i_wb_cyc),
		.i_wb_stb               (i_wb_stb),
		.i_wb_we                (i_wb_we),
		.i_wb_adr               (i_wb_adr),
		.i_wb_dat               (i_wb_dat),
		.i_wb_sel               (i_wb_sel),
		.o_wb_dat               (o_wb_dat),
		.o_wb_ack               (o_wb_ack),
		.i_status               ({24'h0, wake_cnt_q, irq_q, held_err_q,
		                          o_wakeup_done, o_fill_active}),
		.i_syndrome             (syndrome_q),
		.o_ctrl                 (ctrl),
		.o_syndrome_read_strobe (syn_rd)
	);

	assign is_rdwr      = o_cycle_mode_select == EDTC_MODE_RDWR;
	assign rmw_or_scrub = (is_rdwr && (write_q || held_err_q)) || o_cycle_mode_select == EDTC_MODE_SCRUB;
	assign host_rd      = is_rdwr && !write_q;
	assign start        = o_fill_active || refresh_pend_q || i_mem_access;
	// long cycles run to tap eight; a clean read ends at tap four
	assign end_hit      = (held_err_q || !host_rd) ? tap_q[EDTC_TAP_T8] : tap_q[EDTC_TAP_T4];
	assign syn_hit      = i_edc_err && o_cycle_mode_select[1] && o_row_strobe_request
	                      && tap_rise[EDTC_TAP_T3];

	// mode choice: wake-up, then fill, then refresh, then host access
	always_comb begin
		if (o_fill_active && !o_wakeup_done) begin
			mode_d = EDTC_MODE_RESET;
		end else if (o_fill_active) begin
			mode_d = EDTC_MODE_SCRUB;
		end else if (refresh_pend_q) begin
			mode_d = ctrl[EDTC_CTRL_SCRUB] ? EDTC_MODE_SCRUB : EDTC_MODE_REFRESH;
		end else begin
			mode_d = EDTC_MODE_RDWR;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			EDTC_ST_IDLE: if (start) state_d = EDTC_ST_RUN;
			EDTC_ST_RUN:  if (end_hit) state_d = EDTC_ST_END;
			EDTC_ST_END:  state_d = EDTC_ST_IDLE;
			default:      state_d = EDTC_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_q              <= EDTC_ST_IDLE;
			o_row_strobe_request <= 1'b0;
			o_cycle_end          <= 1'b0;
			o_cycle_mode_select  <= EDTC_MODE_RESET;
			write_q              <= 1'b0;
		end else begin
			state_q              <= state_d;
			o_row_strobe_request <= state_d == EDTC_ST_RUN;
			o_cycle_end          <= state_d == EDTC_ST_END;
			if (state_q == EDTC_ST_IDLE && start) begin
				o_cycle_mode_select <= mode_d;
				write_q             <= i_host_write && !o_fill_active && !refresh_pend_q;
			end
		end
	end

	// host refresh: request on the active edge only, since the line outlasts a cycle
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rfr_prev_q     <= 1'b0;
			refresh_pend_q <= 1'b0;
		end else begin
			rfr_prev_q <= i_host_refresh;
			if (i_host_refresh && !rfr_prev_q) begin
				refresh_pend_q <= 1'b1;
			end else if (o_cycle_end && !is_rdwr && !o_fill_active) begin
				refresh_pend_q <= 1'b0;
			end
		end
	end
	assign o_refresh_request = refresh_pend_q;

	// fill latch: power-on and host reset edge start wake-up and fill
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rst_prev_q    <= 1'b0;
			o_fill_active <= 1'b1;
		end else begin
			rst_prev_q <= i_host_reset;
			if (i_host_reset && !rst_prev_q) begin
				o_fill_active <= 1'b1;
			end else if (i_fill_complete && o_wakeup_done) begin
				o_fill_active <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			fill_prev_q   <= 1'b1;
			wake_cnt_q    <= EDTC_WAKE_RST;
			o_wakeup_done <= 1'b0;
		end else begin
			fill_prev_q <= o_fill_active;
			if (!o_fill_active || (o_fill_active && !fill_prev_q)) begin
				wake_cnt_q    <= EDTC_WAKE_RST;
				o_wakeup_done <= 1'b0;
			end else if (wake_cnt_q == EDTC_WAKE_LAST) begin
				// the eighth cycle runs at count seven; its tap eight ends wake-up
				if (tap_rise[EDTC_TAP_T8]) begin
					o_wakeup_done <= 1'b1;
				end
			end else if (tap_rise[EDTC_TAP_T8] && o_cycle_mode_select == EDTC_MODE_RESET) begin
				wake_cnt_q <= wake_cnt_q + 4'h1;
			end
		end
	end

	// held error assumes the worst until tap two proves the read clean
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			held_err_q <= 1'b0;
		end else if (o_cycle_end) begin
			held_err_q <= 1'b1;
		end else if (tap_rise[EDTC_TAP_T2]) begin
			held_err_q <= i_edc_err;
		end
	end

	// set wins over a syndrome read in the same cycle
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			irq_q <= 1'b0;
		end else if (tap_rise[EDTC_TAP_T4] && i_edc_merr && is_rdwr) begin
			irq_q <= 1'b1;
		end else if (syn_rd) begin
			irq_q <= 1'b0;
		end
	end
	assign o_multibit_irq = irq_q && ctrl[EDTC_CTRL_IRQEN];

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			syndrome_q           <= EDTC_SYND_RST;
			o_syndrome_capture_n <= 1'b1;
		end else begin
			o_syndrome_capture_n <= !syn_hit;
			if (syn_hit) begin
				syndrome_q <= i_check_bits;
			end
		end
	end

	// edc and bus transceiver strobes, all from registered taps
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_pulsed_column_strobe      <= 1'b0;
			o_bank_write                <= 3'h0;
			o_edc_out_latch_or_generate <= 1'b0;
			o_edc_input_capture         <= 1'b1;
			o_system_latch_open         <= 1'b0;
		end else begin
			// second column pulse writes the corrected word back
			o_pulsed_column_strobe <= rmw_or_scrub && o_row_strobe_request
				&& ((tap_q[EDTC_TAP_T2] && !tap_q[EDTC_TAP_T3])
				|| (tap_q[EDTC_TAP_T6] && !tap_q[EDTC_TAP_T7]));
			o_bank_write <= (o_row_strobe_request && (rmw_or_scrub || o_fill_active)
				&& tap_q[EDTC_TAP_T5] && !tap_q[EDTC_TAP_T7])
				? bank_decode(i_bank_sel) : 3'h0;
			o_edc_out_latch_or_generate <= o_row_strobe_request && !o_fill_active
				&& tap_q[EDTC_TAP_T2] && !(write_q && !tap_q[EDTC_TAP_T3]);
			// fill keeps the latch closed so its held word seeds every location
			o_edc_input_capture <= !o_fill_active
				&& !(o_row_strobe_request && tap_q[EDTC_TAP_T3]);
			o_system_latch_open <= o_row_strobe_request && host_rd
				&& tap_q[EDTC_TAP_T2] && !tap_q[EDTC_TAP_T5];
		end
	end

	// host write term opens the lanes on writes; on reads they open only while the system latch is open
	always_comb begin
		byte_sel            = byte_decode(i_addr_lo, i_high_byte_en_n);
		o_byte_write_sel    = (write_q && is_rdwr) ? byte_sel : 4'h0;
		o_low_half_drive_n  = !(i_mem_access && !i_addr_lo[1] && (i_host_write || !write_q));
		o_high_half_drive_n = !(i_mem_access && i_addr_lo[1] && (i_host_write || !write_q));
		o_lane_gate         = byte_sel & {4{i_mem_access && (o_system_latch_open || i_host_write)}};
	end

	mode_enc_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$rose(o_row_strobe_request) && o_fill_active && !o_wakeup_done
		|-> o_cycle_mode_select == EDTC_MODE_RESET) else $error("wake-up cycle not in reset mode");
	row_start_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		state_q == EDTC_ST_IDLE && start |=> o_row_strobe_request) else $error("row request late");
	end_idle_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_cycle_end |=> state_q == EDTC_ST_IDLE && !o_cycle_end) else $error("cycle end did not idle");
	wake_stop_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_wakeup_done && o_fill_active |=> wake_cnt_q == EDTC_WAKE_LAST) else $error("wake counter moved");
	wake_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_wakeup_done && o_fill_active && !i_fill_complete |=> o_wakeup_done) else $error("done dropped");
	fill_set_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		i_host_reset && !rst_prev_q |=> o_fill_active) else $error("fill not set by reset edge");
	err_set_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_cycle_end |=> held_err_q) else $error("held error not set at cycle end");
	irq_set_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		tap_rise[EDTC_TAP_T4] && i_edc_merr && is_rdwr |=> irq_q) else $error("irq not raised");
	cas_gate_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_pulsed_column_strobe |-> $past(rmw_or_scrub)) else $error("column pulse outside rmw or scrub");
	synd_cap_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!o_syndrome_capture_n |-> syndrome_q == $past(i_check_bits)) else $error("syndrome not captured");
	rfr_req_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$rose(i_host_refresh) |=> o_refresh_request) else $error("refresh request missing");

endmodule // edtc_core

// >>> tb/edtc_far_model.sv
// Purpose: far side model: delay line taps and dram controller fill count
// Assumes: taps follow the row strobe request, spaced by i_step cycles
// Notes:   taps drop at once when the request falls, as a real delay line does
`timescale 1ns/1ps
module edtc_far_model
	import edtc_pkg::*;
#(
	parameter int unsigned FILL_N = 4
)
(
	input  wire logic                  i_mclk,
	input  wire logic                  i_sys_rst,
	input  wire logic [3:0]            i_step,
	input  wire logic                  i_row_strobe_request,
	input  wire edtc_mode_t            i_cycle_mode_select,
	input  wire logic                  i_cycle_end,
	input  wire logic                  i_fill_active,
	output logic      [EDTC_NTAPS-1:0] o_delay_tap,
	output logic                       o_fill_complete
);
	logic [7:0] age_q;
	logic [7:0] fills_q;
	edtc_mode_t mode_q;
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst)
			age_q <= 8'h00;
		else if (!i_row_strobe_request)
			age_q <= 8'h00;
		else if (age_q != 8'hff)
			age_q <= age_q + 8'h01;
	end
	always_comb begin
		for (int n = 0; n < EDTC_NTAPS; n++)
			o_delay_tap[n] = i_row_strobe_request && (age_q >= 8'((n + 1) * i_step));
	end
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst)
			mode_q <= EDTC_MODE_RESET;
		else if (i_row_strobe_request)
			mode_q <= i_cycle_mode_select;
	end
	// only fill cycles count, so scrub refreshes outside fill never finish a fill
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst)
			fills_q <= 8'h00;
		else if (!i_fill_active)
			fills_q <= 8'h00;
		else if (i_cycle_end && mode_q == EDTC_MODE_SCRUB && fills_q != 8'hff)
			fills_q <= fills_q + 8'h01;
	end
	assign o_fill_complete = (fills_q >= 8'(FILL_N));
endmodule // edtc_far_model

// >>> tb/edtc_core_tb_top.sv
// Purpose: self-checking bench for the dram timing control core
// Assumes: far side model supplies the taps and fill complete
// Notes:   host accesses come from a fixed xorshift seed
`timescale 1ns/1ps
module edtc_core_tb_top
	import edtc_pkg::*;
;
	logic                  i_mclk, i_sys_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
	logic [7:0]            i_wb_adr;
	logic [31:0]           i_wb_dat, o_wb_dat, rd, r;
	logic [3:0]            i_wb_sel, o_byte_write_sel, o_lane_gate, cap_bws, cap_lg, step;
	logic                  i_host_reset, i_host_refresh, i_mem_access, i_host_write, i_high_byte_en_n;
	logic [1:0]            i_addr_lo, i_bank_sel, cap_half;
	logic [EDTC_NTAPS-1:0] i_delay_tap;
	logic                  i_fill_complete, i_edc_err, i_edc_merr;
	logic [8:0]            i_check_bits;
	edtc_mode_t            o_cycle_mode_select;
	logic                  o_row_strobe_request, o_cycle_end, o_refresh_request, o_multibit_irq;
	logic                  o_pulsed_column_strobe, o_edc_out_latch_or_generate, o_edc_input_capture;
	logic                  o_system_latch_open, o_low_half_drive_n, o_high_half_drive_n;
	logic                  o_syndrome_capture_n, o_wakeup_done, o_fill_active;
	logic [2:0]            o_bank_write, saw_bw;
	logic                  saw_t8, saw_col, saw_syn, saw_lo, saw_leo;
	logic                  rr_d = 1'b0;
	logic [31:0]           seed = 32'h0001_2439;
	int                    n_wake = 0;
	int                    mismatches = 0;
	int                    compares = 0;

	edtc_core i_edtc_core (
		.i_mclk, .i_sys_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_dat,
		.o_wb_ack, .i_host_reset, .i_host_refresh, .i_mem_access, .i_host_write, .i_addr_lo,
		.i_high_byte_en_n, .i_bank_sel, .i_delay_tap, .i_fill_complete, .i_edc_err, .i_edc_merr,
		.i_check_bits, .o_row_strobe_request, .o_cycle_mode_select, .o_cycle_end, .o_refresh_request,
		.o_multibit_irq, .o_pulsed_column_strobe, .o_bank_write, .o_edc_out_latch_or_generate,
		.o_edc_input_capture, .o_system_latch_open, .o_low_half_drive_n, .o_high_half_drive_n,
		.o_byte_write_sel, .o_lane_gate, .o_syndrome_capture_n, .o_wakeup_done, .o_fill_active
	);
	edtc_far_model #(.FILL_N(4)) i_edtc_far_model (
		.i_mclk, .i_sys_rst, .i_step(step), .i_row_strobe_request(o_row_strobe_request),
		.i_cycle_mode_select(o_cycle_mode_select), .i_cycle_end(o_cycle_end),
		.i_fill_active(o_fill_active), .o_delay_tap(i_delay_tap), .o_fill_complete(i_fill_complete)
	);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [3:0] exp_bws(input logic [1:0] a, input logic hb_n);
		logic [1:0] p;
		p = {~hb_n, ~a[0]};
		return a[1] ? {p, 2'b00} : {2'b00, p};
	endfunction
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask
	task automatic await(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v) begin
			@(posedge i_mclk);
			n++;
			if (n > 3000) begin
				mismatches++;
				report_and_stop();
			end
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] q);
		int n;
		@(posedge i_mclk);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_adr <= adr;
		i_wb_dat <= wd;
		i_wb_sel <= 4'hf;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 100);
		if (o_wb_ack !== 1'b1) begin
			mismatches++;
			report_and_stop();
		end
		q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
	endtask
	task automatic clr();
		{saw_t8, saw_col, saw_syn, saw_lo, saw_leo, saw_bw} = '0;
	endtask
	// one host access; inputs held until the cycle end pulse
	task automatic access(input logic [31:0] v, input logic wr, input logic er, input logic me);
		logic [2:0] bw;
		bw = v[4] ? 3'b100 : (v[3] ? 3'b010 : 3'b001);
		@(posedge i_mclk);
		clr();
		i_host_write <= wr;
		i_edc_err <= er;
		i_edc_merr <= me;
		i_addr_lo <= v[1:0];
		i_high_byte_en_n <= v[2];
		i_bank_sel <= v[4] ? 2'd2 : {1'b0, v[3]};
		i_check_bits <= v[16:8];
		i_mem_access <= 1'b1;
		await(o_row_strobe_request, 1'b1);
		chk("mode", 32'(EDTC_MODE_RDWR), 32'(o_cycle_mode_select));
		await(o_cycle_end, 1'b1);
		i_mem_access <= 1'b0;
		chk("long_cycle", 32'(wr | er), 32'(saw_t8));
		chk("syn_capture", 32'(er), 32'(saw_syn));
		if (!wr)
			chk("half_drive", {30'h0, v[1], ~v[1]}, 32'(cap_half));
		if (!wr)
			chk("latch_open", 32'h1, 32'(saw_lo));
		if (wr)
			chk("byte_sel", 32'(exp_bws(v[1:0], v[2])), 32'(cap_bws));
		if (wr || !er)
			chk("lane_gate", 32'(exp_bws(v[1:0], v[2])), 32'(cap_lg));
		chk("edc_out", 32'h1, 32'(saw_leo));
		if (!er)
			chk("bank_write", wr ? 32'(bw) : 32'h0, 32'(saw_bw));
		if (!wr && !er)
			chk("col_pulse", 32'h0, 32'(saw_col));
	endtask

	// sampled at the edge, before the design's updates for that edge land
	always @(posedge i_mclk) begin
		if (o_row_strobe_request && !rr_d && o_cycle_mode_select === EDTC_MODE_RESET)
			n_wake++;
		rr_d = o_row_strobe_request;
		if (o_row_strobe_request) begin
			saw_t8 |= i_delay_tap[EDTC_TAP_T8];
			saw_col |= o_pulsed_column_strobe;
			saw_syn |= ~o_syndrome_capture_n;
			saw_lo |= o_system_latch_open;
			saw_leo |= o_edc_out_latch_or_generate;
			saw_bw |= o_bank_write;
			if (i_delay_tap[EDTC_TAP_T3]) begin
				cap_half = {o_low_half_drive_n, o_high_half_drive_n};
				cap_bws = o_byte_write_sel;
				cap_lg = o_lane_gate;
			end
		end
	end

	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end

	initial begin
		i_sys_rst = 1'b1;
		step = 4'h1;
		{i_wb_cyc, i_wb_stb, i_wb_we, i_host_reset, i_host_refresh, i_mem_access} = '0;
		{i_host_write, i_edc_err, i_edc_merr, i_high_byte_en_n} = '0;
		{i_wb_adr, i_wb_dat, i_wb_sel, i_addr_lo, i_bank_sel, i_check_bits} = '0;
		repeat (16) @(posedge i_mclk);
		chk("rst_mode", 32'(EDTC_MODE_RESET), 32'(o_cycle_mode_select));
		chk("rst_state", 32'h7, 32'({o_row_strobe_request, o_multibit_irq, o_wakeup_done, o_fill_active,
			o_edc_input_capture, o_syndrome_capture_n}));
		i_sys_rst <= 1'b0;
		wb(1'b0, EDTC_ADR_CTRL, 32'h0, rd);
		chk("ctrl_rst", 32'(EDTC_CTRL_RST), rd);
		wb(1'b1, 8'h0c, 32'hffff_ffff, rd);
		wb(1'b0, 8'h0c, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		await(o_wakeup_done, 1'b1);
		chk("wake_cycles", 32'h8, 32'(n_wake));
		chk("fill_held", 32'h1, 32'(o_fill_active));
		chk("fill_latch", 32'h0, 32'(o_edc_input_capture));
		wb(1'b0, EDTC_ADR_STATUS, 32'h0, rd);
		chk("wake_count", 32'(EDTC_WAKE_LAST), 32'(rd[7:4]));
		await(o_fill_active, 1'b0);
		@(posedge i_mclk);
		chk("done_clear", 32'h0, 32'(o_wakeup_done));
		// a fill cycle may start on the edge fill falls; let it finish first
		await(o_row_strobe_request, 1'b0);
		step <= 4'h3;
		for (int k = 0; k < 16; k++) begin
			r = rnd();
			access(r, k < 4 ? k[0] : r[0], k < 4 ? k[1] : (r[7:5] == 3'h0), 1'b0);
			if (i_edc_err) begin
				wb(1'b0, EDTC_ADR_SYND, 32'h0, rd);
				chk("syndrome", 32'(r[16:8]), rd);
			end
		end
		access(rnd(), 1'b0, 1'b1, 1'b1);
		chk("irq_set", 32'h1, 32'(o_multibit_irq));
		wb(1'b0, EDTC_ADR_SYND, 32'h0, rd);
		repeat (2) @(posedge i_mclk);
		chk("irq_clear", 32'h0, 32'(o_multibit_irq));
		for (int s = 0; s < 2; s++) begin
			wb(1'b1, EDTC_ADR_CTRL, 32'(2 + s), rd);
			@(posedge i_mclk);
			clr();
			i_edc_err <= 1'b1;
			i_host_refresh <= 1'b1;
			await(o_row_strobe_request, 1'b1);
			chk("rfsh_mode", s ? 32'(EDTC_MODE_SCRUB) : 32'(EDTC_MODE_REFRESH), 32'(o_cycle_mode_select));
			chk("rfsh_req", 32'h1, 32'(o_refresh_request));
			await(o_cycle_end, 1'b1);
			i_host_refresh <= 1'b0;
			i_edc_err <= 1'b0;
			chk("rfsh_col", 32'(s), 32'(saw_col));
			chk("rfsh_syn", 32'h0, 32'(saw_syn));
		end
		@(posedge i_mclk);
		i_host_reset <= 1'b1;
		await(o_fill_active, 1'b1);
		chk("fill_again", 32'h1, 32'(o_fill_active));
		i_host_reset <= 1'b0;
		await(o_fill_active, 1'b0);
		report_and_stop();
	end
endmodule // edtc_core_tb_top
